// *** hdl/bit_controller_sequencer.sv ***
// Overview of operation
// RULE1 - address shifts out serially each shift cycle
// RULE2 - shift clock pulses track address bit changes
// RULE3 - external register parallel-loads memory data
// RULE4 - shift instruction in while address shifts out
// RULE5 - alternate shift/load; execute after full instruction
// RULE6 - fetch address increments once per cycle
// RULE7 - jumps fetch from the operand address
// RULE8 - load or decrement any of four counters
// RULE9 - set or clear any one-bit register
// RULE10 - load accumulator with true or inverted operand
// RULE11 - combine accumulator with operand, result back
// RULE12 - store accumulator true/inverted into bit or latch
// RULE13 - twelve-bit program counter plus backup copy
// RULE14 - sixteen-bit instruction register filled serially
// RULE15 - three-deep stack for calls and vector one
// RULE16 - four request flags jump to fixed vectors
// RULE17 - counters clocked externally or internally
// RULE18 - counter zero is testable by instructions
// RULE19 - three scratch flags via scratch field
// RULE20 - twelve storage flags written and read back
// RULE21 - twelve output latches drive pins
// RULE22 - selector routes flag or input to logic unit
// RULE23 - thirteen clocks: twelve shift, one load
// RULE24 - instruction enters lsb first, eight clocks/cycle
// RULE25 - vectors prioritised, addresses 2 4 6 8
// RULE26 - master clear stops clock, clears, presets
// RULE27 - full stack push drops oldest entry
`timescale 1ns/1ps
module bit_controller_sequencer
    import seq_pkg::*;
#(
    parameter logic [7:0] HALF_CYCLES = 8'(SCK_HALF_CYCLES)
)
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [11:0] awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [11:0] araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    input  wire logic        master_clear,
    input  wire logic        opcode_serial_input,
    input  wire logic [3:0]  vectored_interrupt_input,
    input  wire logic [3:0]  count_input,
    input  wire logic [11:0] sense_input,
    output logic             shift_clock,
    output logic             address_out,
    output logic             shift_load,
    output logic [11:0]      pin_output_latch
);
    // ======================================================================
    // state
    typedef struct packed {
        logic             sin_m, sin_s, master_clear_m, master_clear_s;
        logic [11:0]      sense_m, sense_s;
        logic [3:0]       cnt_m, cnt_s, cnt_d, vec_m, vec_s, vec_d;
        logic [7:0]       div;
        logic [3:0]       bitn;
        logic             sck, sdo, sload;
        phase_type        phase;
        logic [11:0]      pc, cyc_addr, backup;
        logic [15:0]      ir;
        logic [2:0][11:0] stk;
        logic             af;
        logic [3:0]       req, cnt_int;
        logic [3:0][11:0] cnt;
        logic [11:0]      stor, latch;
        logic [2:0]       temp;
        logic             run, awready, bvalid, arready, rvalid;
        logic [1:0]       bresp, rresp;
        logic [31:0]      rdata;
    } state_type;

    state_type   r_reg, r_next;
    logic        tick, rise, fall, exec, gany, blk, jmp, wval, opnd;
    logic [1:0]  gidx, lc_idx, cls, csel;
    logic [2:0]  op;
    logic [1:0]  tf;
    logic [3:0]  idx, req_clr, zero;
    logic [11:0] nf, nxt;
    logic [31:0] rd;

    assign tick   = r_reg.div == HALF_CYCLES - 8'h01;
    // a halted sequencer parks only at the start of a cycle
    assign rise   = tick && !r_reg.sck && !r_reg.master_clear_s
                    && (r_reg.run || r_reg.bitn != 4'h0);
    assign fall   = tick && r_reg.sck;
    assign exec   = rise && r_reg.bitn == LOAD_CLOCK
                    && r_reg.phase == PH_HIGH; // see RULE5
    assign op     = r_reg.ir[F_OP_HI:F_OP_LO];
    assign nf     = r_reg.ir[11:0];
    assign tf     = r_reg.ir[F_TMP_HI:F_TMP_LO];
    assign cls    = r_reg.ir[F_CLS_HI:F_CLS_LO];
    assign idx    = r_reg.ir[F_IDX_HI:F_IDX_LO];
    assign csel   = nf[1:0];
    assign lc_idx = 2'(op - OP_LC1);
    assign req_clr = (exec && gany) ? 4'(4'h1 << gidx) : 4'h0;

    // ======================================================================
    // operand steering and vector priority
    always_comb
    begin
        opnd = 1'b0;
        if (tf != 2'h0)
            opnd = r_reg.temp[2'(tf - 2'h1)]; // see RULE19
        else if (idx < 4'(NUM_FLAGS))
        begin
            case (cls)
                CLS_PIN:  opnd = r_reg.sense_s[idx]; // see RULE22
                CLS_STOR: opnd = r_reg.stor[idx];    // see RULE20
                CLS_ACC:  opnd = r_reg.af;
                default:  opnd = 1'b0;
            endcase
        end
        opnd = opnd ^ r_reg.ir[F_INV];
        gany = 1'b0;
        gidx = 2'h0;
        blk  = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            // a higher input held high keeps lower requests waiting
            if (!gany && !blk && r_reg.req[i])
            begin
                gany = 1'b1;
                gidx = 2'(i); // see RULE25
            end
            blk = blk | r_reg.vec_s[i];
        end
        for (int k = 0; k < 4; k++)
            zero[k] = r_reg.cnt[k] == 12'h000; // see RULE18
    end

    // ======================================================================
    // next state
    always_comb
    begin
        r_next = r_reg;
        jmp = 1'b0;
        nxt = r_reg.cyc_addr;
        wval = 1'b0;
        rd = 32'h0000_0000;
        r_next.sin_m = opcode_serial_input;
        r_next.sin_s = r_reg.sin_m;
        r_next.master_clear_m = master_clear;
        r_next.master_clear_s = r_reg.master_clear_m;
        r_next.sense_m = sense_input;
        r_next.sense_s = r_reg.sense_m;
        r_next.cnt_m = count_input;
        r_next.cnt_s = r_reg.cnt_m;
        r_next.cnt_d = r_reg.cnt_s;
        r_next.vec_m = vectored_interrupt_input;
        r_next.vec_s = r_reg.vec_m;
        r_next.vec_d = r_reg.vec_s;
        // new edge wins over the service clear
        r_next.req = (r_reg.req & ~req_clr)
                     | (r_reg.vec_s & ~r_reg.vec_d); // see RULE16
        for (int k = 0; k < 4; k++)
        begin
            if (r_reg.cnt_int[k] ? (rise && r_reg.bitn == 4'h0)
                                 : (r_reg.cnt_s[k] && !r_reg.cnt_d[k]))
                r_next.cnt[k] = r_reg.cnt[k] - 12'h001; // see RULE17
        end
        r_next.div = tick ? 8'h00 : r_reg.div + 8'h01;
        if (rise)
        begin
            r_next.sck = 1'b1; // see RULE2
            r_next.sload = r_reg.bitn == LOAD_CLOCK; // see RULE23
            if (r_reg.bitn == 4'h0)
            begin
                r_next.cyc_addr = r_reg.pc;
                r_next.pc = r_reg.pc + 12'h001; // see RULE6
                r_next.sdo = r_reg.pc[11]; // see RULE1
            end
            else if (r_reg.bitn < LOAD_CLOCK)
                r_next.sdo = r_reg.cyc_addr[ADDR_MSB - r_reg.bitn];
            else
                r_next.sdo = 1'b0;
            // the far register has parallel-loaded its byte by now
            if (r_reg.bitn < IR_CLOCKS)
                r_next.ir = {r_reg.sin_s, r_reg.ir[15:1]}; // see RULE24
            if (r_reg.bitn == LOAD_CLOCK)
            begin
                case (r_reg.phase)
                    PH_JUNK: r_next.phase = PH_LOW;
                    PH_LOW:  r_next.phase = PH_HIGH;
                    default: r_next.phase = PH_LOW;
                endcase
            end
        end
        if (fall)
        begin
            r_next.sck = 1'b0;
            r_next.bitn = (r_reg.bitn == LOAD_CLOCK) ? 4'h0
                          : r_reg.bitn + 4'h1; // see RULE4
        end
        if (exec)
        begin
            r_next.backup = r_reg.cyc_addr; // see RULE13
            if (r_reg.ir[F_GROUP])
            begin
                case (op)
                    LOP_LD:  r_next.af = opnd; // see RULE10
                    LOP_AND: r_next.af = r_reg.af & opnd; // see RULE11
                    LOP_OR:  r_next.af = r_reg.af | opnd;
                    LOP_XOR: r_next.af = r_reg.af ^ opnd;
                    default: r_next.af = r_reg.af;
                endcase
                wval = (op == LOP_SET)
                       || (op == LOP_ST && (r_reg.af ^ r_reg.ir[F_INV]));
                if (op == LOP_ST || op == LOP_SET || op == LOP_CLR)
                begin
                    if (tf != 2'h0)
                        r_next.temp[2'(tf - 2'h1)] = wval; // see RULE9
                    else if (idx < 4'(NUM_FLAGS))
                    begin
                        case (cls)
                            CLS_PIN:  r_next.latch[idx] = wval; // see RULE12
                            CLS_STOR: r_next.stor[idx] = wval; // see RULE20
                            CLS_ACC:  r_next.af = wval;
                            default:  r_next.af = r_next.af;
                        endcase
                    end
                end
            end
            else if (op >= OP_LC1 && op <= OP_LC4)
                r_next.cnt[lc_idx] = nf; // see RULE8
            else if (op == OP_MISC)
            begin
                case (nf[F_SUB_HI:F_SUB_LO])
                    SUB_DEC:
                        r_next.cnt[csel] = r_reg.cnt[csel] - 12'h001;
                    SUB_RET:
                    begin
                        nxt = r_reg.stk[0];
                        jmp = 1'b1;
                        r_next.backup = r_reg.stk[0]; // see RULE15
                        r_next.stk = {12'h000, r_reg.stk[2:1]};
                    end
                    SUB_SRC:
                        r_next.cnt_int[csel] = nf[F_CSRC]; // see RULE17
                    SUB_SKIP:
                    begin
                        if (zero[csel]) // see RULE18
                        begin
                            nxt = r_reg.cyc_addr + SKIP_STEP;
                            jmp = 1'b1;
                        end
                    end
                    default:
                        jmp = 1'b0;
                endcase
            end
            else if (op == OP_JMP || op == OP_JS)
            begin
                if (op == OP_JS) // see RULE27
                    r_next.stk = {r_reg.stk[1:0], r_reg.cyc_addr};
                nxt = nf; // see RULE7
                jmp = 1'b1;
            end
            if (gany)
            begin
                if (gidx == 2'h0)
                    r_next.stk = {r_next.stk[1:0], nxt}; // see RULE25
                nxt = VECTOR_ADDR[gidx]; // see RULE16
                jmp = 1'b1;
            end
            // a jump discards the byte already in flight
            r_next.phase = jmp ? PH_JUNK : PH_LOW;
            if (jmp)
                r_next.pc = nxt;
        end
        if (r_reg.master_clear_s) // see RULE26
        begin
            r_next.pc = 12'h000;
            r_next.req = 4'h0;
            r_next.latch = 12'h000;
            r_next.temp = 3'h0;
            r_next.stor = 12'h000;
            r_next.cnt = {4{CNT_PRESET}};
            r_next.sck = 1'b0;
            r_next.sdo = 1'b0;
            r_next.sload = 1'b0;
            r_next.bitn = 4'h0;
            r_next.div = 8'h00;
            r_next.phase = PH_JUNK;
        end
        // register bus: write waits for both address and data
        if (r_reg.awready)
        begin
            r_next.awready = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = RESP_OKAY;
            if (awaddr == REG_CTRL && wstrb[0])
                r_next.run = wdata[0];
            else if (awaddr != REG_STATUS && awaddr != REG_FLAGS
                     && awaddr != REG_INSTR
                     && awaddr[11:4] != REG_CNT_ROW)
                r_next.bresp = RESP_SLVERR;
        end
        else if (awvalid && wvalid && !r_reg.bvalid)
            r_next.awready = 1'b1;
        if (r_reg.bvalid && bready)
            r_next.bvalid = 1'b0;
        rd[ST_PHASE_LO +: 2] = r_reg.phase;
        rd[ST_REQ_LO +: 4] = r_reg.req;
        rd[ST_ZERO_LO +: 4] = zero;
        rd[ST_AF] = r_reg.af;
        rd[11:0] = r_reg.pc;
        if (r_reg.arready)
        begin
            r_next.arready = 1'b0;
            r_next.rvalid = 1'b1;
            r_next.rresp = RESP_OKAY;
            if (araddr == REG_CTRL)
                r_next.rdata = {31'h0000_0000, r_reg.run};
            else if (araddr == REG_STATUS)
                r_next.rdata = rd;
            else if (araddr == REG_FLAGS)
                r_next.rdata = {5'h00, r_reg.temp, r_reg.stor,
                                r_reg.latch};
            else if (araddr == REG_INSTR)
                r_next.rdata = {16'h0000, r_reg.ir};
            else if (araddr[11:4] == REG_CNT_ROW)
                r_next.rdata = {20'h0_0000, r_reg.cnt[araddr[3:2]]};
            else
            begin
                r_next.rdata = 32'h0000_0000;
                r_next.rresp = RESP_SLVERR;
            end
        end
        else if (arvalid && !r_reg.rvalid)
            r_next.arready = 1'b1;
        if (r_reg.rvalid && rready)
            r_next.rvalid = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r_reg <= '0;
            r_reg.cnt <= {4{CNT_PRESET}};
            r_reg.run <= CTRL_RESET;
        end
        else
            r_reg <= r_next;
    end

    assign awready = r_reg.awready;
    assign wready = r_reg.awready;
    assign bvalid = r_reg.bvalid;
    assign bresp = r_reg.bresp;
    assign arready = r_reg.arready;
    assign rvalid = r_reg.rvalid;
    assign rdata = r_reg.rdata;
    assign rresp = r_reg.rresp;
    assign shift_clock = r_reg.sck;
    assign address_out = r_reg.sdo;
    assign shift_load = r_reg.sload;
    assign pin_output_latch = r_reg.latch; // see RULE21

    // ======================================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_load_marks_13th: assert property (rise |=> shift_load ==
        ($past(r_reg.bitn) == LOAD_CLOCK)) // see RULE23
        else $error("load control not on the thirteenth clock");
    a_sck_high_time: assert property ($rose(shift_clock) |->
        shift_clock [*4] ##1 !shift_clock) // see RULE2
        else $error("shift clock high time wrong");
    a_first_addr_bit: assert property (rise && r_reg.bitn == 4'h0
        |=> address_out == $past(r_reg.pc[11])) // see RULE1
        else $error("address msb not first");
    a_pc_increment: assert property (rise && r_reg.bitn == 4'h0
        |=> r_reg.pc == $past(r_reg.pc) + 12'h001) // see RULE6
        else $error("fetch address did not advance");
    a_ir_lsb_entry: assert property (rise && r_reg.bitn < IR_CLOCKS
        |=> r_reg.ir[15] == $past(r_reg.sin_s)) // see RULE24
        else $error("instruction bit not shifted in");
    a_jump_target: assert property (exec && !r_reg.ir[F_GROUP]
        && op == OP_JMP && !gany
        |=> r_reg.pc == $past(nf) && r_reg.phase == PH_JUNK) // see RULE7
        else $error("jump did not redirect fetch");
    a_counter_load: assert property (exec && !r_reg.ir[F_GROUP]
        && op >= OP_LC1 && op <= OP_LC4
        |=> r_reg.cnt[$past(lc_idx)] == $past(nf)) // see RULE8
        else $error("counter not loaded");
    a_vector_dest: assert property (exec && gany
        |=> r_reg.pc == VECTOR_ADDR[$past(gidx)]) // see RULE16
        else $error("vector address wrong");
    a_call_push: assert property (exec && !r_reg.ir[F_GROUP]
        && op == OP_JS && !gany
        |=> r_reg.stk[0] == $past(r_reg.cyc_addr)) // see RULE15
        else $error("call did not push return address");
    a_clear_state: assert property (r_reg.master_clear_s |=> r_reg.pc == 12'h000
        && r_reg.latch == 12'h000 && (&r_reg.cnt)) // see RULE26
        else $error("master clear incomplete");
    a_write_resp: assert property (awvalid && awready && wvalid
        |=> bvalid) else $error("write response missing");

    c_exec: cover property (exec);
    c_vector: cover property (exec && gany);
    c_skip_taken: cover property (exec && op == OP_MISC && jmp);
endmodule // bit_controller_sequencer

// *** shared/seq_pkg.sv ***
// ==========================================================================
// shared constants of the bit sequencer
package seq_pkg;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          SCK_PERIOD_NS   = 80;
    // half period of the shift clock in aclk cycles, rounded up
    localparam int          SCK_HALF_CYCLES = (SCK_PERIOD_NS
                                              + 2 * CLK_PERIOD_NS - 1)
                                              / (2 * CLK_PERIOD_NS);
    localparam logic [3:0]  LOAD_CLOCK      = 4'hC;
    localparam logic [3:0]  IR_CLOCKS       = 4'h8;
    localparam logic [3:0]  ADDR_MSB        = 4'hB;
    localparam logic [11:0] CNT_PRESET      = 12'hFFF;
    localparam logic [11:0] SKIP_STEP       = 12'h002;
    localparam logic [3:0][11:0] VECTOR_ADDR =
        {12'h008, 12'h006, 12'h004, 12'h002};
    localparam int          NUM_FLAGS       = 12;
    // ======================================================================
    // instruction fields
    localparam int          F_GROUP  = 15;
    localparam int          F_OP_HI  = 14;
    localparam int          F_OP_LO  = 12;
    localparam int          F_INV    = 11;
    localparam int          F_TMP_HI = 10;
    localparam int          F_TMP_LO = 9;
    localparam int          F_SUB_HI = 11;
    localparam int          F_SUB_LO = 8;
    localparam int          F_CLS_HI = 5;
    localparam int          F_CLS_LO = 4;
    localparam int          F_IDX_HI = 3;
    localparam int          F_IDX_LO = 0;
    localparam int          F_CSRC   = 2;
    localparam logic [2:0]  OP_LC1   = 3'h1;
    localparam logic [2:0]  OP_LC4   = 3'h4;
    localparam logic [2:0]  OP_MISC  = 3'h5;
    localparam logic [2:0]  OP_JMP   = 3'h6;
    localparam logic [2:0]  OP_JS    = 3'h7;
    localparam logic [3:0]  SUB_DEC  = 4'h0;
    localparam logic [3:0]  SUB_RET  = 4'h1;
    localparam logic [3:0]  SUB_SRC  = 4'h2;
    localparam logic [3:0]  SUB_SKIP = 4'h3;
    localparam logic [2:0]  LOP_LD   = 3'h0;
    localparam logic [2:0]  LOP_AND  = 3'h1;
    localparam logic [2:0]  LOP_OR   = 3'h2;
    localparam logic [2:0]  LOP_XOR  = 3'h3;
    localparam logic [2:0]  LOP_ST   = 3'h4;
    localparam logic [2:0]  LOP_SET  = 3'h5;
    localparam logic [2:0]  LOP_CLR  = 3'h6;
    localparam logic [1:0]  CLS_PIN  = 2'h0;
    localparam logic [1:0]  CLS_STOR = 2'h1;
    localparam logic [1:0]  CLS_ACC  = 2'h2;
    // ======================================================================
    // register map
    localparam logic [11:0] REG_CTRL    = 12'h000;
    localparam logic [11:0] REG_STATUS  = 12'h004;
    localparam logic [11:0] REG_FLAGS   = 12'h008;
    localparam logic [11:0] REG_INSTR   = 12'h00C;
    localparam logic [7:0]  REG_CNT_ROW = 8'h01;
    localparam logic        CTRL_RESET  = 1'b1;
    localparam int          ST_PHASE_LO = 28;
    localparam int          ST_REQ_LO   = 24;
    localparam int          ST_ZERO_LO  = 20;
    localparam int          ST_AF       = 16;
    localparam int          FL_TEMP_LO  = 24;
    localparam int          FL_STOR_LO  = 12;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    typedef enum logic [1:0]
    {
        PH_JUNK = 2'h0,
        PH_LOW  = 2'h1,
        PH_HIGH = 2'h3
    } phase_type;
endpackage

// *** tb/fetch_memory_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// interface shift register in front of a byte-wide memory
module fetch_memory_model
(
    input  wire logic aresetn,
    input  wire logic shift_clock,
    input  wire logic address_out,
    input  wire logic shift_load,
    output logic      opcode_serial_input
);
    logic [7:0]  mem [0:4095];
    logic [11:0] addr_sr = 12'h000;
    logic [7:0]  data_sr = 8'hA5;
    int          edges = 0;
    int          load_q[$];
    assign opcode_serial_input = data_sr[0];
    // falling edge: the address bit has been stable for half a clock
    always @(negedge shift_clock iff aresetn)
    begin
        edges++;
        if (shift_load)
        begin
            data_sr = mem[addr_sr];
            load_q.push_back(edges * 4096 + addr_sr);
            edges = 0;
        end
        else
        begin
            addr_sr = {addr_sr[10:0], address_out};
            // spent bits toggle so a stale level cannot pass for data
            data_sr = {~data_sr[0], data_sr[7:1]};
        end
    end
endmodule // fetch_memory_model

// *** tb/tb.sv ***
`timescale 1ns/1ps
`define chk(g, e) \
    begin \
        check_count++; \
        if ((g) !== (e)) \
        begin \
            err_count++; \
            $display("mismatch %0t got %h want %h", $time, g, e); \
        end \
    end
// ==========================================================
// sequencer bench: fetch link, logic ops, vectors, registers
module tb;
    import seq_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        master_clear, awready, wready, bvalid, arready, rvalid;
    logic        shift_clock, address_out, shift_load, opcode_serial_input;
    logic [1:0]  bresp, rresp, rs;
    logic [3:0]  wstrb, vectored_interrupt_input, count_input;
    logic [11:0] awaddr, araddr, sense_input, pin_output_latch;
    logic [31:0] wdata, rdata, rd;
    int          err_count, check_count, cycles, v, e, exp_lat;
    // skip vectors; vector 2 sets latch 7; acc = ~sense 3; latch 5 = acc;
    // set latch 0; counter 1 = 0x123; spin at 0x018
    int          pa[8] = '{0, 4, 6, 16, 18, 20, 22, 24};
    logic [15:0] pw[8] = '{16'h6010, 16'hD007, 16'h6018, 16'h8803,
                           16'hC005, 16'hD000, 16'h1123, 16'h6018};
    bit_controller_sequencer #(.HALF_CYCLES(8'h04))
        i_bit_controller_sequencer (.*);
    fetch_memory_model i_fetch_memory_model (.*);
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // the whole run needs roughly 22 fetch cycles of 104 aclk each
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
            close_out(1);
    end
    task automatic close_out(input int extra);
        err_count += extra;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic axi(input bit wr, input logic [11:0] a,
                       output logic [31:0] d, output logic [1:0] r);
        {awaddr, araddr, wdata} <= {a, a, 32'h00000001};
        {awvalid, wvalid, arvalid} <= {wr, wr, !wr};
        do @(posedge aclk); while ((wr ? awready : arready) !== 1'b1);
        {awvalid, wvalid, arvalid} <= 3'h0;
        do @(posedge aclk); while ((wr ? bvalid : rvalid) !== 1'b1);
        d = rdata;
        r = wr ? bresp : rresp;
    endtask
    initial
    begin
        v = $urandom(32'hA05463CB);
        {aresetn, awvalid, wvalid, arvalid, master_clear} = 5'h00;
        {bready, rready, wstrb, sense_input} = 18'h3F000;
        {awaddr, araddr, wdata} = 56'h0;
        {vectored_interrupt_input, count_input} = 8'h00;
        for (int i = 0; i < 4096; i++)
            i_fetch_memory_model.mem[i] = 8'h00;
        foreach (pa[i])
        begin
            i_fetch_memory_model.mem[pa[i]] = pw[i][7:0];
            i_fetch_memory_model.mem[pa[i] + 1] = pw[i][15:8];
        end
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        sense_input <= 12'($urandom());
        while (i_fetch_memory_model.load_q.size() < 14)
            @(posedge aclk);
        for (int i = 0; i < 14; i++)
        begin
            e = i_fetch_memory_model.load_q[i];
            `chk(e / 4096, 13)
            `chk(e % 4096, (i < 3) ? i : i + 13)
        end
        exp_lat = sense_input[3] ? 1 : 33;
        `chk(pin_output_latch, 12'(exp_lat))
        axi(1'b0, REG_FLAGS, rd, rs);
        `chk(rd[11:0], 12'(exp_lat))
        axi(1'b0, 12'h010, rd, rs);
        `chk(rd[11:0], 12'h123)
        axi(1'b0, 12'h0FC, rd, rs);
        `chk(rs, RESP_SLVERR)
        axi(1'b1, REG_CTRL, rd, rs);
        `chk(rs, RESP_OKAY)
        axi(1'b1, 12'h0F0, rd, rs);
        `chk(rs, RESP_SLVERR)
        vectored_interrupt_input <= 4'h2;
        for (int n = 0; n < 3000 && pin_output_latch[7] !== 1'b1; n++)
            @(posedge aclk);
        vectored_interrupt_input <= 4'h0;
        `chk(pin_output_latch, 12'(exp_lat + 128))
        master_clear <= 1'b1;
        repeat (30) @(posedge aclk);
        `chk(pin_output_latch, 12'h000)
        `chk(shift_clock, 1'b0)
        axi(1'b0, 12'h010, rd, rs);
        `chk(rd[11:0], CNT_PRESET)
        v = i_fetch_memory_model.load_q.size();
        master_clear <= 1'b0;
        while (i_fetch_memory_model.load_q.size() < v + 1)
            @(posedge aclk);
        `chk(i_fetch_memory_model.load_q[v] % 4096, 0)
        close_out(0);
    end
endmodule // tb
